// *** rtl/rvu_top.sv ***
`timescale 1ns/100ps
// How it works
// - Frequency is judged by the time between alternating threshold crossings.
// - Interval longer than the six-bit timeout means frequency too low.
// - Interval shorter than the six-bit minimum count means frequency too high.
// - Three-bit duration sets how long frequency must stay in tolerance.
// - After validation, ring ends when no threshold hit occurs for the four-bit timeout.
// - Delay timer starts at validation; ring indicated only if it beats ring end.
// - One enable bit switches validation on or off, also in sleep.
// - With validation on, the status bit shows the validated ring envelope.
// - Flag sets on status rise, or on both edges when edge select set.
// - Interrupt pin follows the masked flag with selectable polarity.
// - Indicator pin follows envelope, or a five second retriggered one-shot.
// - Flag stays set until host writes one to clear it.
// - Status bit is forced to zero while off-hook.
module rvu_top #(
  parameter int unsigned TICK_CYCLES = rvu_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [rvu_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ring_pos_in,
  input wire logic ring_neg_in,
  input wire logic off_hook_in,
  output logic irq,
  output logic int_pin,
  output logic ring_indicator_pin_o,
  output logic ring_indicator_pin_oe_n
);
  import rvu_pkg::*;

  // Pin synchronisers with agreement filter
  wire [2:0] pins_w = {off_hook_in, ring_neg_in, ring_pos_in};
  logic [2:0] s1_q, s2_q, s3_q, flt_q, prev_q;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          flt_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= pins_w[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          flt_q[gi] <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
          prev_q[gi] <= flt_q[gi];
        end
      end
    end
  endgenerate

  // Configuration and state registers
  logic [3:0] ctrl_q;
  logic [5:0] min_freq_q, ring_max_freq_count_q;
  logic [2:0] ring_confirm_duration_q, ring_indicate_delay_q;
  logic [3:0] ring_end_timeout_q;
  logic ring_irq_mask_q, ring_irq_flag_q, ring_irq_flag_d;
  logic done_q;
  logic [31:0] rdata_q;
  rvu_state_t state_q, state_d;
  logic [IVL_W-1:0] ivl_q, ivl_d;
  logic [CNT_W-1:0] dur_q, dur_d, eto_q, eto_d, dly_q, dly_d;
  logic env_q, env_d;
  logic [1:0] last_pol_q, last_pol_d;
  logic [OS_W-1:0] os_q, os_d;
  logic ring_envelope_status_q, status_d;
  logic ind_q, int_pin_q;
  logic tick;

  wire ring_validation_enable = ctrl_q[CTRL_EN_BIT-4];
  wire ring_both_edge_select = ctrl_q[CTRL_BOTH_BIT-4];
  wire full_wave_select = ctrl_q[CTRL_FW_BIT-4];
  wire int_pol_high = ctrl_q[CTRL_POL_BIT-4];
  wire pos_f = flt_q[0];
  wire neg_f = flt_q[1];
  wire off_hook = flt_q[2];
  wire pos_rise = flt_q[0] & ~prev_q[0];
  wire neg_rise = flt_q[1] & ~prev_q[1];
  wire hit = pos_rise | neg_rise;
  wire crossing = (pos_rise && last_pol_q == POL_NEG) || (neg_rise && last_pol_q == POL_POS);
  wire run = ring_validation_enable && !off_hook;
  wire os_hit = pos_rise | (full_wave_select & neg_rise);
  wire [CNT_W-1:0] conf_lim = CNT_W'(ring_confirm_duration_q * CONF_UNIT);
  wire [CNT_W-1:0] end_lim = CNT_W'(ring_end_timeout_q * END_UNIT);
  wire [CNT_W-1:0] dly_lim = CNT_W'(ring_indicate_delay_q * DLY_UNIT);
  wire oneshot = (os_q != '0);

  // Fixed tick for the validation timers
  rvu_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(1'b1),
    .tick(tick)
  );

  // Avalon slave, one wait state on every access
  wire req = avs_read | avs_write;
  wire acc = req & done_q;
  wire wr = avs_write & acc;
  wire wr_b0 = wr & avs_byteenable[0];
  wire wr_b1 = wr & avs_byteenable[1];
  wire sel_ctrl = (avs_address == OFF_CTRL);
  wire sel_min = (avs_address == OFF_MIN_FREQ);
  wire sel_max = (avs_address == OFF_MAX_FREQ);
  wire sel_tim = (avs_address == OFF_TIMING);
  wire sel_stat = (avs_address == OFF_STATUS);
  wire sel_irq = (avs_address == OFF_IRQ_STAT);
  wire sel_mask = (avs_address == OFF_IRQ_MASK);
  wire irq_clr = wr_b0 & sel_irq & avs_writedata[0];
  wire [31:0] rd_mux =
    sel_ctrl ? {24'h000000, ctrl_q, 4'h0} :
    sel_min ? {26'h0000000, min_freq_q} :
    sel_max ? {26'h0000000, ring_max_freq_count_q} :
    sel_tim ? {21'h000000, ring_indicate_delay_q, ring_end_timeout_q, 1'b0, ring_confirm_duration_q} :
    sel_stat ? {26'h0000000, state_q, neg_f, pos_f, oneshot, ring_envelope_status_q} :
    sel_irq ? {31'h00000000, ring_irq_flag_q} :
    sel_mask ? {31'h00000000, ring_irq_mask_q} : 32'h00000000;
  assign avs_waitrequest = req & ~done_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      done_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      done_q <= req & ~done_q;
      if (req && !done_q)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RST;
      min_freq_q <= MIN_FREQ_RST;
      ring_max_freq_count_q <= MAX_FREQ_RST;
      ring_confirm_duration_q <= CONF_RST;
      ring_end_timeout_q <= END_RST;
      ring_indicate_delay_q <= DLY_RST;
      ring_irq_mask_q <= 1'b0;
    end
    else
    begin
      if (wr_b0 && sel_ctrl)
        ctrl_q <= avs_writedata[7:4];
      if (wr_b0 && sel_min)
        min_freq_q <= avs_writedata[5:0];
      if (wr_b0 && sel_max)
        ring_max_freq_count_q <= avs_writedata[5:0];
      if (wr_b0 && sel_tim)
      begin
        ring_confirm_duration_q <= avs_writedata[TIM_CONF_LSB +: 3];
        ring_end_timeout_q <= avs_writedata[TIM_END_LSB +: 4];
      end
      if (wr_b1 && sel_tim)
        ring_indicate_delay_q <= avs_writedata[TIM_DLY_LSB +: 3];
      if (wr_b0 && sel_mask)
        ring_irq_mask_q <= avs_writedata[0];
    end
  end

  // Validation sequencer
  always_comb
  begin
    state_d = state_q;
    ivl_d = ivl_q;
    dur_d = dur_q;
    eto_d = eto_q;
    dly_d = dly_q;
    env_d = env_q;
    last_pol_d = pos_rise ? POL_POS : (neg_rise ? POL_NEG : last_pol_q);
    if (!run)
    begin
      state_d = ST_IDLE;
      ivl_d = '0;
      dur_d = '0;
      eto_d = '0;
      dly_d = '0;
      env_d = 1'b0;
      last_pol_d = POL_NONE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (hit)
          begin
            state_d = ST_CHECK;
            ivl_d = '0;
            dur_d = '0;
          end
        ST_CHECK:
          if (crossing)
          begin
            ivl_d = '0;
            if (IVL_W'(ring_max_freq_count_q) > ivl_q)
              dur_d = '0;
          end
          else if (tick)
          begin
            if (ivl_q > IVL_W'(min_freq_q))
              state_d = ST_IDLE;
            else if (dur_q >= conf_lim)
            begin
              state_d = ST_VALID;
              eto_d = '0;
              dly_d = '0;
            end
            else
            begin
              ivl_d = ivl_q + 1'b1;
              dur_d = dur_q + 1'b1;
            end
          end
        ST_VALID:
        begin
          if (tick)
          begin
            if (!hit && eto_q >= end_lim)
            begin
              state_d = ST_IDLE;
              env_d = 1'b0;
            end
            else
            begin
              eto_d = eto_q + 1'b1;
              if (dly_q >= dly_lim)
                env_d = 1'b1;
              else
                dly_d = dly_q + 1'b1;
            end
          end
          if (hit)
            eto_d = '0;
        end
        default:
          state_d = ST_IDLE;
      endcase
    end
  end

  // Unqualified one-shot, retriggered by positive threshold hits, and by negative ones only when full wave select is set
  assign os_d = off_hook ? '0 : (os_hit ? OS_W'(ONESHOT_TICKS) : ((tick && oneshot) ? os_q - 1'b1 : os_q));
  assign status_d = off_hook ? 1'b0 : (ring_validation_enable ? env_q : oneshot);
  wire st_rise = status_d & ~ring_envelope_status_q;
  wire st_fall = ~status_d & ring_envelope_status_q;
  wire irq_set = st_rise | (ring_both_edge_select & st_fall);
  assign ring_irq_flag_d = irq_set | (ring_irq_flag_q & ~irq_clr);
  wire irq_line = ring_irq_flag_q & ring_irq_mask_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      ivl_q <= '0;
      dur_q <= '0;
      eto_q <= '0;
      dly_q <= '0;
      env_q <= 1'b0;
      last_pol_q <= POL_NONE;
      os_q <= '0;
      ring_envelope_status_q <= 1'b0;
      ring_irq_flag_q <= 1'b0;
      ind_q <= 1'b0;
      int_pin_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      ivl_q <= ivl_d;
      dur_q <= dur_d;
      eto_q <= eto_d;
      dly_q <= dly_d;
      env_q <= env_d;
      last_pol_q <= last_pol_d;
      os_q <= os_d;
      ring_envelope_status_q <= status_d;
      ring_irq_flag_q <= ring_irq_flag_d;
      ind_q <= full_wave_select ? oneshot : status_d;
      int_pin_q <= int_pol_high ? irq_line : ~irq_line;
    end
  end

  // Outputs; indicator is open drain, pulled low when asserted
  assign irq = irq_line;
  assign int_pin = int_pin_q;
  assign ring_indicator_pin_o = 1'b0;
  assign ring_indicator_pin_oe_n = ~ind_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_irq_clear_write;
    avs_write && done_q && sel_irq && avs_byteenable[0] && avs_writedata[0];
  endsequence

  property p_offhook_zero;
    off_hook |=> !ring_envelope_status_q;
  endproperty
  a_offhook_zero: assert property (p_offhook_zero) else $error("status high while off-hook");

  property p_irq_on_rise;
    $rose(ring_envelope_status_q) |-> ring_irq_flag_q;
  endproperty
  a_irq_on_rise: assert property (p_irq_on_rise) else $error("flag not set on status rise");

  property p_no_fall_irq;
    !ring_irq_flag_q && !ring_both_edge_select ##1 $fell(ring_envelope_status_q) |-> !ring_irq_flag_q;
  endproperty
  a_no_fall_irq: assert property (p_no_fall_irq) else $error("flag set on fall without edge select");

  property p_flag_holds;
    ring_irq_flag_q && !irq_clr |=> ring_irq_flag_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped without clear");

  property p_flag_clears;
    s_irq_clear_write ##0 !irq_set |=> !ring_irq_flag_q;
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared by write");

  property p_int_pin;
    ##1 1'b1 |-> int_pin_q == ($past(int_pol_high) ? $past(irq_line) : !$past(irq_line));
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("interrupt pin wrong level");

  property p_disable_idle;
    !ring_validation_enable |=> state_q == ST_IDLE && !env_q && dur_q == '0;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("sequencer active while disabled");

  property p_too_low;
    run && state_q == ST_CHECK && !crossing && tick && ivl_q > IVL_W'(min_freq_q) |=> state_q == ST_IDLE;
  endproperty
  a_too_low: assert property (p_too_low) else $error("low frequency not rejected");

  property p_too_high;
    run && state_q == ST_CHECK && crossing && ivl_q < IVL_W'(ring_max_freq_count_q) |=> dur_q == '0 && ivl_q == '0;
  endproperty
  a_too_high: assert property (p_too_high) else $error("high frequency not rejected");

  property p_env_after_valid;
    $rose(env_q) |-> $past(state_q) == ST_VALID && $past(dly_q) >= $past(dly_lim);
  endproperty
  a_env_after_valid: assert property (p_env_after_valid) else $error("envelope rose before delay");

  property p_end_idle;
    run && state_q == ST_VALID && tick && !hit && eto_q >= end_lim |=> state_q == ST_IDLE && !env_q;
  endproperty
  a_end_idle: assert property (p_end_idle) else $error("ring end not taken");

  property p_fw_pin;
    full_wave_select && os_hit && !off_hook |=> ##1 !ring_indicator_pin_oe_n;
  endproperty
  a_fw_pin: assert property (p_fw_pin) else $error("indicator not asserted on one-shot");
endmodule

// *** rtl/rvu_pkg.sv ***
`timescale 1ns/100ps
package rvu_pkg;
  // Register byte offsets
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_MIN_FREQ = 5'h04;
  localparam logic [4:0] OFF_MAX_FREQ = 5'h08;
  localparam logic [4:0] OFF_TIMING = 5'h0C;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18;
  // Control field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_BOTH_BIT = 6;
  localparam int CTRL_FW_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  // Timing field positions
  localparam int TIM_CONF_LSB = 0;
  localparam int TIM_END_LSB = 4;
  localparam int TIM_DLY_LSB = 8;
  // Status field positions
  localparam int ST_ENV_BIT = 0;
  localparam int ST_OS_BIT = 1;
  localparam int ST_POS_BIT = 2;
  localparam int ST_NEG_BIT = 3;
  localparam int ST_FSM_LSB = 4;
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [5:0] MIN_FREQ_RST = 6'h24;
  localparam logic [5:0] MAX_FREQ_RST = 6'h07;
  localparam logic [2:0] CONF_RST = 3'h2;
  localparam logic [3:0] END_RST = 4'h3;
  localparam logic [2:0] DLY_RST = 3'h0;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int ONESHOT_MS = 5000;
  localparam int ONESHOT_TICKS = ONESHOT_MS * 1000 / TICK_US;
  localparam int CONF_UNIT = 64;
  localparam int END_UNIT = 64;
  localparam int DLY_UNIT = 256;
  localparam int DIV_W = 24;
  localparam int IVL_W = 7;
  localparam int CNT_W = 12;
  localparam int OS_W = 13;
  // Last threshold seen
  localparam logic [1:0] POL_NONE = 2'h0;
  localparam logic [1:0] POL_POS = 2'h1;
  localparam logic [1:0] POL_NEG = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_VALID} rvu_state_t;
endpackage

module rvu_tick #(
  parameter int unsigned DIV = 10000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic run,
  output logic tick
);
  import rvu_pkg::*;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  wire last_w = (cnt_q == DIV_W'(DIV - 1));

  // Divider restarts whenever it is stopped
  assign cnt_d = (!run || last_w) ? '0 : cnt_q + 1'b1;
  assign tick = run && last_w;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

// *** testbench/rvu_ring_src.sv ***
`timescale 1ns/100ps
module rvu_ring_src (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [7:0] ivl,
  output logic pos,
  output logic neg
);
  logic [7:0] cnt = 8'h00;
  logic phase = 1'b0;
  // Alternate the two comparator flags, one crossing per ivl cycles
  always @(posedge sys_clk)
  begin
    if (!run)
    begin
      pos <= 1'b0;
      neg <= 1'b0;
      cnt <= 8'h00;
    end
    else if (cnt == 8'h00)
    begin
      pos <= !phase;
      neg <= phase;
      phase <= !phase;
      cnt <= ivl - 8'h01;
    end
    else
      cnt <= cnt - 8'h01;
  end
endmodule

// *** testbench/test_rvu_top.sv ***
`timescale 1ns/100ps
module test_rvu_top;
  import rvu_pkg::*;
  localparam int TC = 4;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ring_pos_in;
  logic ring_neg_in;
  logic off_hook_in = 1'b0;
  logic irq;
  logic int_pin;
  logic ind_o;
  logic ind_oe_n;
  logic ring_run = 1'b0;
  logic [7:0] ring_ivl = 8'h10;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'h6F420906;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int bad_base[2] = '{1, 12};
  int bad_n[2] = '{100, 30};

  // Clock keeps running throughout, sleep included
  always #50 sys_clk = ~sys_clk;

  rvu_top #(.TICK_CYCLES(TC)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ring_pos_in(ring_pos_in), .ring_neg_in(ring_neg_in), .off_hook_in(off_hook_in), .irq(irq),
    .int_pin(int_pin), .ring_indicator_pin_o(ind_o), .ring_indicator_pin_oe_n(ind_oe_n));

  rvu_ring_src u_src (.sys_clk(sys_clk), .run(ring_run), .ivl(ring_ivl), .pos(ring_pos_in),
    .neg(ring_neg_in));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read data is settled before the completing edge
  always @(negedge sys_clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    int n = 0;
    if (!wr)
    begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    @(posedge sys_clk);
    if (n >= 50)
    begin
      errors++;
      $display("CHECK FAILED at %0t: bus wait timed out", $time);
      test_done();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask

  task automatic reg_rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, e, m);
  endtask

  // Bits are irq, int_pin, indicator enable, indicator data
  task automatic pins(input logic [3:0] e, input logic [3:0] m);
    @(negedge sys_clk);
    check({irq, int_pin, ind_oe_n, ind_o} & m, e & m);
    @(posedge sys_clk);
  endtask

  task automatic wait_env(input logic lvl, input int lim);
    int n = 0;
    while (ind_oe_n !== lvl && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      $display("CHECK FAILED at %0t: indicator wait timed out", $time);
      test_done();
    end
    @(posedge sys_clk);
  endtask

  task automatic ring(input int n, input int base);
    ring_run <= 1'b1;
    repeat (n)
    begin
      ring_ivl <= 8'(TC * base + ($random(seed) & 3));
      repeat (TC * base) @(posedge sys_clk);
    end
    ring_run <= 1'b0;
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    reg_rd(OFF_CTRL, 32'h0, 32'hF0);
    reg_rd(OFF_MIN_FREQ, 32'h24, 32'h3F);
    reg_rd(OFF_MAX_FREQ, 32'h07, 32'h3F);
    reg_rd(OFF_TIMING, 32'h032, 32'h7F7);
    reg_wr(5'h1C, $random(seed));
    reg_rd(5'h1C, 32'h0, 32'hFFFFFFFF);
    pins(4'b0110, 4'hF);
    $display("test reset done");
    reg_wr(OFF_MIN_FREQ, 32'h08);
    reg_wr(OFF_MAX_FREQ, 32'h02);
    reg_wr(OFF_TIMING, 32'h011);
    reg_wr(OFF_IRQ_MASK, 32'h1);
    reg_wr(OFF_CTRL, 32'h80);
    ring(40, 4);
    reg_rd(OFF_STATUS, 32'h21, 32'h31);
    pins(4'b1000, 4'hF);
    repeat (TC * 48) @(posedge sys_clk);
    pins(4'b0000, 4'h2);
    wait_env(1'b1, 150);
    pins(4'b1010, 4'hF);
    reg_wr(OFF_IRQ_STAT, 32'h1);
    pins(4'b0100, 4'hC);
    $display("test valid ring done");
    reg_wr(OFF_CTRL, 32'hD0);
    ring(40, 4);
    pins(4'b1100, 4'hC);
    reg_wr(OFF_IRQ_STAT, 32'h1);
    pins(4'b0000, 4'hC);
    wait_env(1'b1, 400);
    repeat (4) @(posedge sys_clk);
    pins(4'b1100, 4'hC);
    reg_wr(OFF_IRQ_STAT, 32'h1);
    $display("test both edges done");
    reg_wr(OFF_CTRL, 32'h80);
    ring(40, 4);
    off_hook_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reg_rd(OFF_STATUS, 32'h0, 32'h1);
    pins(4'b0010, 4'h2);
    off_hook_in <= 1'b0;
    repeat (300) @(posedge sys_clk);
    reg_wr(OFF_IRQ_STAT, 32'h1);
    $display("test off hook done");
    for (int i = 0; i < 2; i++)
    begin
      ring(bad_n[i], bad_base[i]);
      pins(4'b0010, 4'hA);
    end
    $display("test tolerance done");
    reg_wr(OFF_TIMING, 32'h111);
    ring(24, 4);
    repeat (400) @(posedge sys_clk);
    pins(4'b0010, 4'hA);
    ring(100, 4);
    pins(4'b1000, 4'hA);
    reg_wr(OFF_IRQ_STAT, 32'h1);
    wait_env(1'b1, 400);
    pins(4'b0010, 4'hA);
    $display("test delay done");
    reg_wr(OFF_CTRL, 32'h20);
    ring(10, 4);
    pins(4'b0000, 4'h2);
    reg_rd(OFF_STATUS, 32'h0, 32'h30);
    $display("test disabled done");
    test_done();
  end
endmodule
